// ===== pcs_core.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Indirect port redirects to pointer-addressed location
// R2: Memory switch bits 5:4 show current page
// R3: Memory switch bits 2:0 select bank 0-4
// R4: Counter and stack entries are 12 bits
// R5: Return stack holds eight entries
// R6: Pages are 1024 words; low 10 bits
// R7: Any reset clears the whole counter
// R8: Jump-in-page loads low 10 bits only
// R9: Page invoke pushes PC+1, loads low 10
// R10: Long jump loads all 12 counter bits
// R11: Far invoke pushes PC+1, loads 12 bits
// R12: All three exits reload from stack top, pop
// R13: Accumulator add is a full relative add
// R14: Accumulator move replaces low 8 bits only
// R15: Other counter writes keep bits 8 and 9
// R16: One cycle per op, long ones take two
// R17: Held low reset keeps the controller reset
// R18: Pointer bits 5:0 give indirect address
// R19: Only addresses 05-0F are bank steered
// R20: Ninth push overwrites oldest entry silently
module pcs_core (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// APB register port
	input pcs_pkg::pcs_apb_req_t apb_i,
	output pcs_pkg::pcs_apb_rsp_t apb_o,
	// Instruction decoder side
	input pcs_pkg::pcs_instr_t instr_i,
	output logic instr_ready_o,
	// Sequencer view
	output logic [pcs_pkg::PC_W-1:0] pc_o,
	output logic [pcs_pkg::PAGE_W-1:0] page_o,
	output logic [pcs_pkg::BANK_W-1:0] bank_o,
	output logic [pcs_pkg::SP_W-1:0] stack_ptr_o
);

	// Registered state and its next value
	pcs_pkg::pcs_state_t r;
	pcs_pkg::pcs_state_t next_r;

	// Bus phase decode
	logic setup;
	logic access;
	logic aligned;
	// Register index and effective data address
	logic [pcs_pkg::DADDR_W-1:0] idx;
	logic [pcs_pkg::DADDR_W-1:0] ea;
	// Target classes of the effective address
	logic bank_hit;
	logic common_hit;
	logic [pcs_pkg::DADDR_W-1:0] bank_ofs;
	logic [pcs_pkg::DADDR_W-1:0] common_ofs;
	// Write qualifiers
	logic wr_req;
	logic pc_wr_req;
	logic wr_ok;
	// Instruction acceptance
	logic fire;
	// Counter arithmetic
	logic [pcs_pkg::PC_W-1:0] pc_inc;
	logic [pcs_pkg::SP_W-1:0] sp_dec;
	logic [pcs_pkg::PC_W-1:0] stack_top;
	// Read value for the addressed location
	logic [pcs_pkg::PC_W-1:0] rd_val;

	// Address decode; a pointer that itself names the port reads zero
	always_comb begin
		setup = apb_i.psel && !apb_i.penable;
		access = apb_i.psel && apb_i.penable;
		aligned = (apb_i.paddr[1:0] == 2'h0);
		idx = apb_i.paddr[pcs_pkg::APB_AW-1:2];
		// Port access lands on the pointed-to location
		if (idx == pcs_pkg::IDX_INDIRECT_ACCESS_PORT) begin // see R1
			ea = r.pointer[pcs_pkg::DADDR_W-1:0]; // see R18
		end else begin
			ea = idx;
		end
		// Only 05-0F move with the bank; banks past 4 hold nothing
		bank_hit = (ea >= pcs_pkg::IDX_BANKED_FIRST) &&
			(ea <= pcs_pkg::IDX_BANKED_LAST) &&
			(r.bank < pcs_pkg::BANK_W'(pcs_pkg::NUM_BANKS)); // see R19
		common_hit = (ea >= pcs_pkg::IDX_COMMON_FIRST); // see R19
		bank_ofs = ea - pcs_pkg::IDX_BANKED_FIRST;
		common_ofs = ea - pcs_pkg::IDX_COMMON_FIRST;
	end

	// Bus handshake and instruction acceptance
	always_comb begin
		wr_req = access && apb_i.pwrite && aligned;
		pc_wr_req = wr_req && (ea == pcs_pkg::IDX_PROGRAM_COUNTER);
		// A counter write waits out the second cycle of a long op,
		// so the two never fight over the counter
		apb_o.pready = !((r.seq == pcs_pkg::PCS_ST_LONG) && pc_wr_req);
		apb_o.pslverr = access && !aligned;
		apb_o.prdata = r.prdata;
		wr_ok = wr_req && apb_o.pready;
		// The decoder stalls while the bus rewrites the counter
		instr_ready_o = (r.seq == pcs_pkg::PCS_ST_RUN) && !pc_wr_req;
		fire = instr_i.valid && instr_ready_o;
	end

	// Counter helpers; the stack pointer wraps on its own width
	always_comb begin
		pc_inc = r.pc + 12'h001;
		sp_dec = r.sp - 3'h1;
		stack_top = r.stack[sp_dec];
	end

	// Read mux for the addressed data location
	always_comb begin
		rd_val = '0;
		unique case (ea)
			pcs_pkg::IDX_INDIRECT_ACCESS_PORT: begin
				// Nothing is stored behind the port itself
				rd_val = '0; // see R1
			end
			pcs_pkg::IDX_MEMORY_SWITCH: begin
				rd_val[pcs_pkg::MS_PAGE_LSB +: pcs_pkg::PAGE_W] =
					r.pc[pcs_pkg::PC_W-1 -: pcs_pkg::PAGE_W]; // see R2
				rd_val[pcs_pkg::MS_BANK_LSB +: pcs_pkg::BANK_W] =
					r.bank; // see R3
			end
			pcs_pkg::IDX_PROGRAM_COUNTER: begin
				rd_val = r.pc;
			end
			pcs_pkg::IDX_INDIRECT_POINTER: begin
				rd_val[pcs_pkg::DATA_W-1:0] = r.pointer;
			end
			default: begin
				// Status lives elsewhere and reads zero here
				if (bank_hit) begin
					rd_val[pcs_pkg::DATA_W-1:0] =
						r.banked[r.bank][bank_ofs];
				end else if (common_hit) begin
					rd_val[pcs_pkg::DATA_W-1:0] = r.common[common_ofs];
				end
			end
		endcase
	end

	// Next state: bus effects, then the sequencer
	always_comb begin
		next_r = r;
		// Read data is caught in setup and shown in the access phase
		if (setup) begin
			next_r.prdata = '0;
			if (aligned) begin
				next_r.prdata[pcs_pkg::PC_W-1:0] = rd_val;
			end
		end
		// Bus writes
		if (wr_ok) begin
			unique case (ea)
				pcs_pkg::IDX_INDIRECT_ACCESS_PORT: begin
					// Port pointing at itself: write is dropped
				end
				pcs_pkg::IDX_MEMORY_SWITCH: begin
					// Page bits are read-only, only bank is written
					next_r.bank =
						apb_i.pwdata[pcs_pkg::MS_BANK_LSB +:
						pcs_pkg::BANK_W]; // see R3
				end
				pcs_pkg::IDX_PROGRAM_COUNTER: begin
					// Only low 8 bits move; 8 and 9 stay put
					next_r.pc = {r.pc[pcs_pkg::PC_W-1:8],
						apb_i.pwdata[7:0]}; // see R15
				end
				pcs_pkg::IDX_INDIRECT_POINTER: begin
					next_r.pointer =
						apb_i.pwdata[pcs_pkg::DATA_W-1:0]; // see R18
				end
				default: begin
					if (bank_hit) begin
						next_r.banked[r.bank][bank_ofs] =
							apb_i.pwdata[pcs_pkg::DATA_W-1:0];
					end else if (common_hit) begin
						next_r.common[common_ofs] =
							apb_i.pwdata[pcs_pkg::DATA_W-1:0];
					end
				end
			endcase
		end
		// Sequencer
		unique case (r.seq)
			pcs_pkg::PCS_ST_RUN: begin
				if (fire) begin
					unique case (instr_i.op)
						pcs_pkg::PCS_OP_NONE: begin
							// Counter holds
						end
						pcs_pkg::PCS_OP_STEP: begin
							next_r.pc = pc_inc; // see R16
						end
						pcs_pkg::PCS_OP_JUMP_IN_PAGE: begin
							// Page bits kept, offset in page loaded
							next_r.pc = {
								r.pc[pcs_pkg::PC_W-1:pcs_pkg::PAGE_OFS_W],
								instr_i.operand[pcs_pkg::PAGE_OFS_W-1:0]
							}; // see R8 R6
						end
						pcs_pkg::PCS_OP_PAGE_INVOKE: begin
							// Ninth push simply overwrites the oldest
							next_r.stack[r.sp] = pc_inc; // see R9 R5
							next_r.sp = r.sp + 3'h1; // see R20
							next_r.pc = {
								r.pc[pcs_pkg::PC_W-1:pcs_pkg::PAGE_OFS_W],
								instr_i.operand[pcs_pkg::PAGE_OFS_W-1:0]
							}; // see R9
						end
						pcs_pkg::PCS_OP_LONG_JUMP,
						pcs_pkg::PCS_OP_FAR_SUBROUTINE_INVOKE: begin
							// Second word cycle; counter moves after it
							next_r.seq = pcs_pkg::PCS_ST_LONG; // see R16
							next_r.long_target = instr_i.operand;
							next_r.long_push = (instr_i.op ==
								pcs_pkg::PCS_OP_FAR_SUBROUTINE_INVOKE);
						end
						pcs_pkg::PCS_OP_SUBROUTINE_EXIT,
						pcs_pkg::PCS_OP_EXIT_WITH_LITERAL,
						pcs_pkg::PCS_OP_EXIT_FROM_INTERRUPT: begin
							// Underflow wraps silently like overflow
							next_r.pc = stack_top; // see R12
							next_r.sp = sp_dec; // see R12
						end
						pcs_pkg::PCS_OP_ADD_ACC: begin
							// Carry runs through all upper bits
							next_r.pc = r.pc +
								{4'h0, instr_i.acc}; // see R13
						end
						pcs_pkg::PCS_OP_MOV_ACC: begin
							next_r.pc = {r.pc[pcs_pkg::PC_W-1:8],
								instr_i.acc}; // see R14
						end
						default: begin
							// Undefined op codes leave the counter alone
						end
					endcase
				end
			end
			pcs_pkg::PCS_ST_LONG: begin
				// Full 12-bit load; far invoke pushes first
				next_r.pc = r.long_target; // see R10 R11 R4
				if (r.long_push) begin
					next_r.stack[r.sp] = pc_inc; // see R11
					next_r.sp = r.sp + 3'h1; // see R20
				end
				next_r.seq = pcs_pkg::PCS_ST_RUN;
			end
		endcase
	end

	// State register; reset held low keeps everything cleared
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin // see R17
			r <= '0;
			r.seq <= pcs_pkg::PCS_ST_RUN;
			r.pc <= pcs_pkg::PC_RESET; // see R7
			r.sp <= pcs_pkg::SP_RESET;
			r.bank <= pcs_pkg::BANK_RESET;
			r.pointer <= pcs_pkg::POINTER_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Observation outputs, all from flip-flops
	assign pc_o = r.pc;
	assign page_o = r.pc[pcs_pkg::PC_W-1 -: pcs_pkg::PAGE_W];
	assign bank_o = r.bank;
	assign stack_ptr_o = r.sp;

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	// Helper: decode of the accepted operation
	logic op_jip;
	logic op_page_inv;
	logic op_long;
	logic op_far;
	logic op_exit;
	logic op_add;
	logic op_mov;
	logic op_step;
	always_comb begin
		op_jip = fire && (instr_i.op == pcs_pkg::PCS_OP_JUMP_IN_PAGE);
		op_page_inv = fire && (instr_i.op == pcs_pkg::PCS_OP_PAGE_INVOKE);
		op_long = fire && (instr_i.op == pcs_pkg::PCS_OP_LONG_JUMP);
		op_far = fire &&
			(instr_i.op == pcs_pkg::PCS_OP_FAR_SUBROUTINE_INVOKE);
		op_exit = fire &&
			((instr_i.op == pcs_pkg::PCS_OP_SUBROUTINE_EXIT) ||
			(instr_i.op == pcs_pkg::PCS_OP_EXIT_WITH_LITERAL) ||
			(instr_i.op == pcs_pkg::PCS_OP_EXIT_FROM_INTERRUPT));
		op_add = fire && (instr_i.op == pcs_pkg::PCS_OP_ADD_ACC);
		op_mov = fire && (instr_i.op == pcs_pkg::PCS_OP_MOV_ACC);
		op_step = fire && (instr_i.op == pcs_pkg::PCS_OP_STEP);
	end

	chk_pc_reset_clear: assert property ( // see R7
		@(posedge clock_i) disable iff (1'b0)
		!reset_n_i |=> (pc_o == 12'h000) && (stack_ptr_o == 3'h0)
	) else $error("counter not cleared by reset");

	chk_jip_page_kept: assert property ( // see R8
		op_jip |=> (pc_o[11:10] == $past(pc_o[11:10])) &&
			(pc_o[9:0] == $past(instr_i.operand[9:0]))
	) else $error("jump in page changed page bits");

	chk_page_inv_push: assert property ( // see R9
		op_page_inv |=> (r.stack[$past(r.sp)] == $past(pc_o) + 12'h001) &&
			(pc_o[9:0] == $past(instr_i.operand[9:0])) &&
			(stack_ptr_o == $past(stack_ptr_o) + 3'h1)
	) else $error("page invoke push or load wrong");

	chk_long_two_cyc: assert property ( // see R16
		op_long |=> !instr_ready_o && (pc_o == $past(pc_o)) ##1
			(pc_o == $past(instr_i.operand, 2)) && instr_ready_o
	) else $error("long jump not loaded on second cycle");

	chk_far_inv_push: assert property ( // see R11
		op_far |=> ##1 (pc_o == $past(instr_i.operand, 2)) &&
			(r.stack[$past(r.sp, 2)] == $past(pc_o, 2) + 12'h001)
	) else $error("far invoke push or load wrong");

	chk_exit_pop: assert property ( // see R12
		op_exit |=> (pc_o == $past(r.stack[stack_ptr_o - 3'h1])) &&
			(stack_ptr_o == $past(stack_ptr_o) - 3'h1)
	) else $error("exit did not pop stack top");

	chk_add_relative: assert property ( // see R13
		op_add |=> pc_o == $past(pc_o) + {4'h0, $past(instr_i.acc)}
	) else $error("accumulator add not relative");

	chk_mov_low_only: assert property ( // see R14
		op_mov |=> (pc_o[7:0] == $past(instr_i.acc)) &&
			(pc_o[11:8] == $past(pc_o[11:8]))
	) else $error("accumulator move touched high bits");

	chk_pc_wr_keep: assert property ( // see R15
		wr_ok && (ea == pcs_pkg::IDX_PROGRAM_COUNTER) |=>
			(pc_o[9:8] == $past(pc_o[9:8])) &&
			(pc_o[7:0] == $past(apb_i.pwdata[7:0]))
	) else $error("counter write changed bits 8 and 9");

	chk_page_readback: assert property ( // see R2
		setup && aligned && (ea == pcs_pkg::IDX_MEMORY_SWITCH) |=>
			(apb_o.prdata[5:4] == $past(pc_o[11:10])) &&
			(apb_o.prdata[2:0] == $past(bank_o))
	) else $error("memory switch readback wrong");

	chk_bank_select: assert property ( // see R3
		wr_ok && (ea == pcs_pkg::IDX_MEMORY_SWITCH) |=>
			bank_o == $past(apb_i.pwdata[2:0])
	) else $error("bank select not written");

	chk_step_one: assert property ( // see R16
		op_step |=> pc_o == $past(pc_o) + 12'h001
	) else $error("step did not advance by one");

	// Main scenarios
	cov_page_invoke: cover property (op_page_inv ##[1:20] op_exit);
	cov_far_invoke: cover property (op_far ##2 op_exit);
	cov_stack_wrap: cover property (op_page_inv && (r.sp == 3'h7));
	cov_indirect_wr: cover property (wr_ok &&
		(idx == pcs_pkg::IDX_INDIRECT_ACCESS_PORT) && common_hit);

endmodule

// ===== pcs_decoder_model.sv
`timescale 1ns/1ps
// Behavioural instruction decoder: offers one op at a time and holds it
// until the sequencer takes it
module pcs_decoder_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// Handshake with the sequencer
	input wire logic ready_i,
	output pcs_pkg::pcs_instr_t instr_o
);
	// Nothing offered at time zero
	initial instr_o = '0;

	// Offer after an idle gap; the op is held until ready is seen
	task automatic issue(pcs_pkg::pcs_op_t op, logic [11:0] o,
		logic [7:0] a, int gap);
		// No request while the core is held in reset
		do begin
			@(posedge clock_i);
		end while (!reset_n_i);
		repeat (gap) @(posedge clock_i);
		instr_o <= '{valid: 1'b1, op: op, operand: o, acc: a};
		// Waits as long as it takes; the bench watchdog ends a hang
		do begin
			@(posedge clock_i);
		end while (!ready_i);
		// Released fields show inverted junk so stale data cannot pass
		instr_o <= '{valid: 1'b0, op: pcs_pkg::PCS_OP_NONE, operand: ~o,
			acc: ~a};
	endtask
endmodule

// ===== pcs_pkg.sv
package pcs_pkg;

	// Widths of the sequencer and data side
	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 3;
	localparam int PAGE_OFS_W = 10;
	localparam int PAGE_W = 2;
	localparam int DATA_W = 8;
	localparam int DADDR_W = 6;
	localparam int BANK_W = 3;
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;

	// Storage sizes behind the data addresses
	localparam int NUM_BANKS = 5;
	localparam int BANKED_WORDS = 11;
	localparam int COMMON_WORDS = 48;

	// Register indices; the APB byte address is four times the index
	localparam logic [DADDR_W-1:0] IDX_INDIRECT_ACCESS_PORT = 6'h00;
	localparam logic [DADDR_W-1:0] IDX_MEMORY_SWITCH = 6'h01;
	localparam logic [DADDR_W-1:0] IDX_PROGRAM_COUNTER = 6'h02;
	localparam logic [DADDR_W-1:0] IDX_STATUS = 6'h03;
	localparam logic [DADDR_W-1:0] IDX_INDIRECT_POINTER = 6'h04;
	localparam logic [DADDR_W-1:0] IDX_BANKED_FIRST = 6'h05;
	localparam logic [DADDR_W-1:0] IDX_BANKED_LAST = 6'h0F;
	localparam logic [DADDR_W-1:0] IDX_COMMON_FIRST = 6'h10;

	// Field positions in the memory switch register
	localparam int MS_BANK_LSB = 0;
	localparam int MS_PAGE_LSB = 4;

	// Values after reset
	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [SP_W-1:0] SP_RESET = 3'h0;
	localparam logic [BANK_W-1:0] BANK_RESET = 3'h0;
	localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;

	// Operations issued by the instruction decoder
	typedef enum logic [3:0] {
		PCS_OP_NONE,
		PCS_OP_STEP,
		PCS_OP_JUMP_IN_PAGE,
		PCS_OP_PAGE_INVOKE,
		PCS_OP_LONG_JUMP,
		PCS_OP_FAR_SUBROUTINE_INVOKE,
		PCS_OP_SUBROUTINE_EXIT,
		PCS_OP_EXIT_WITH_LITERAL,
		PCS_OP_EXIT_FROM_INTERRUPT,
		PCS_OP_ADD_ACC,
		PCS_OP_MOV_ACC
	} pcs_op_t;

	// Sequencer phases
	typedef enum logic {PCS_ST_RUN, PCS_ST_LONG} pcs_seq_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [APB_AW-1:0] paddr;
		logic [APB_DW-1:0] pwdata;
	} pcs_apb_req_t;

	typedef struct packed {
		logic [APB_DW-1:0] prdata;
		logic pready;
		logic pslverr;
	} pcs_apb_rsp_t;

	typedef struct packed {
		logic valid;
		pcs_op_t op;
		logic [PC_W-1:0] operand;
		logic [DATA_W-1:0] acc;
	} pcs_instr_t;

	typedef struct packed {
		pcs_seq_t seq;
		logic [PC_W-1:0] pc;
		logic [SP_W-1:0] sp;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
		logic [PC_W-1:0] long_target;
		logic long_push;
		logic [BANK_W-1:0] bank;
		logic [DATA_W-1:0] pointer;
		logic [NUM_BANKS-1:0][BANKED_WORDS-1:0][DATA_W-1:0] banked;
		logic [COMMON_WORDS-1:0][DATA_W-1:0] common;
		logic [APB_DW-1:0] prdata;
	} pcs_state_t;

endpackage

// ===== tb_program_counter_stack_banking.sv
`timescale 1ns/1ps
module tb_program_counter_stack_banking;
	// Design hookup
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	pcs_pkg::pcs_apb_req_t apb_req = '0;
	pcs_pkg::pcs_apb_rsp_t apb_rsp;
	pcs_pkg::pcs_instr_t instr;
	logic instr_ready_o;
	logic [11:0] pc_o;
	logic [1:0] page_o;
	logic [2:0] bank_o;
	logic [2:0] stack_ptr_o;
	// Reference counter and return stack
	logic [11:0] rpc = 12'h000;
	logic [11:0] rstk [8];
	logic [2:0] rsp = 3'h0;
	logic [31:0] rd;
	logic slverr;
	int fails = 0;
	int comparisons = 0;
	int seed = 55318;

	always #4 clock_i = ~clock_i;

	pcs_core dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.apb_i(apb_req), .apb_o(apb_rsp), .instr_i(instr),
		.instr_ready_o(instr_ready_o), .pc_o(pc_o), .page_o(page_o),
		.bank_o(bank_o), .stack_ptr_o(stack_ptr_o));
	pcs_decoder_model dec_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.ready_i(instr_ready_o), .instr_o(instr));

	// Value compare, counted
	task automatic compare(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd,
		output logic [31:0] r);
		@(posedge clock_i);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
			pwdata: wd};
		@(posedge clock_i);
		apb_req.penable <= 1'b1;
		// No cycle count assumed; the watchdog ends a hang
		do begin
			@(posedge clock_i);
		end while (!apb_rsp.pready);
		r = apb_rsp.prdata;
		slverr = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	// Counter value expected after an op
	function automatic logic [11:0] expect_pc(pcs_pkg::pcs_op_t op,
		logic [11:0] o, logic [7:0] a);
		case (op)
			pcs_pkg::PCS_OP_JUMP_IN_PAGE,
			pcs_pkg::PCS_OP_PAGE_INVOKE: return {rpc[11:10], o[9:0]};
			pcs_pkg::PCS_OP_LONG_JUMP,
			pcs_pkg::PCS_OP_FAR_SUBROUTINE_INVOKE: return o;
			pcs_pkg::PCS_OP_ADD_ACC: return rpc + 12'(a);
			pcs_pkg::PCS_OP_MOV_ACC: return {rpc[11:8], a};
			pcs_pkg::PCS_OP_STEP: return rpc + 12'h001;
			pcs_pkg::PCS_OP_NONE: return rpc;
			default: return rstk[rsp - 3'h1];
		endcase
	endfunction

	// Issue one op, track the reference, check the outcome
	task automatic do_op(pcs_pkg::pcs_op_t op, logic [11:0] o, logic [7:0] a);
		logic [11:0] e;
		e = expect_pc(op, o, a);
		dec_u.issue(op, o, a, $random(seed) & 3);
		if (op inside {pcs_pkg::PCS_OP_LONG_JUMP,
			pcs_pkg::PCS_OP_FAR_SUBROUTINE_INVOKE}) begin
			#1;
			compare(32'(instr_ready_o), 32'h0);
			compare(32'(pc_o), 32'(rpc));
			@(posedge clock_i);
		end
		// Pushes wrap over the oldest slot
		if (op inside {pcs_pkg::PCS_OP_PAGE_INVOKE,
			pcs_pkg::PCS_OP_FAR_SUBROUTINE_INVOKE}) begin
			rstk[rsp] = rpc + 12'h001;
			rsp++;
		end else if (op inside {[pcs_pkg::PCS_OP_SUBROUTINE_EXIT:
			pcs_pkg::PCS_OP_EXIT_FROM_INTERRUPT]}) begin
			rsp--;
		end
		rpc = e;
		#1;
		compare(32'(pc_o), 32'(rpc));
		compare(32'(stack_ptr_o), 32'(rsp));
		compare(32'(page_o), 32'(rpc[11:10]));
	endtask

	// Verdict and end of run
	task automatic results();
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock_i);
		fails++;
		results();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clock_i);
		reset_n_i <= 1'b1;
		#1;
		compare(32'(pc_o), 32'h0);
		compare(32'(bank_o), 32'h0);
		apb(1'b0, 8'h08, 32'h0, rd);
		compare(rd, 32'h0);
		// Carry into bit 9, then a low byte move keeps bits 8 and 9
		do_op(pcs_pkg::PCS_OP_LONG_JUMP, 12'h1FE, 8'h00);
		do_op(pcs_pkg::PCS_OP_ADD_ACC, 12'h000, 8'h05);
		do_op(pcs_pkg::PCS_OP_MOV_ACC, 12'h000, 8'h44);
		// Nine nested invokes overrun the stack, then all exit kinds
		for (int i = 0; i < 9; i++) begin
			do_op(i[0] ? pcs_pkg::PCS_OP_PAGE_INVOKE
				: pcs_pkg::PCS_OP_FAR_SUBROUTINE_INVOKE,
				12'($random(seed)), 8'h00);
		end
		for (int i = 0; i < 9; i++) begin
			do_op(pcs_pkg::pcs_op_t'(4'h6 + 4'(i % 3)), 12'h000, 8'h00);
		end
		// Random mix of every op, stack already filled
		for (int i = 0; i < 300; i++) begin
			do_op(pcs_pkg::pcs_op_t'(4'({$random(seed)} % 11)),
				12'($random(seed)), 8'($random(seed)));
		end
		// Bank field writable, page and pad bits not
		for (int b = 0; b < 5; b++) begin
			apb(1'b1, 8'h04, 32'hF8 | 32'(b), rd);
			apb(1'b0, 8'h04, 32'h0, rd);
			compare(rd, {26'h0, rpc[11:10], 1'b0, 3'(b)});
			compare(32'(bank_o), 32'(b));
			apb(1'b1, 8'h14, 32'hA0 + 32'(b), rd);
			apb(1'b1, 8'h40, 32'h30 + 32'(b), rd);
		end
		// Window 05-0F is per bank, 10 upward is shared
		for (int b = 0; b < 5; b++) begin
			apb(1'b1, 8'h04, 32'(b), rd);
			apb(1'b0, 8'h14, 32'h0, rd);
			compare(rd, 32'hA0 + 32'(b));
			apb(1'b0, 8'h40, 32'h0, rd);
			compare(rd, 32'h34);
		end
		// Port reaches the location named by the pointer
		apb(1'b1, 8'h10, 32'h25, rd);
		apb(1'b1, 8'h00, 32'h5A, rd);
		apb(1'b0, 8'h94, 32'h0, rd);
		compare(rd, 32'h5A);
		apb(1'b0, 8'h00, 32'h0, rd);
		compare(rd, 32'h5A);
		// Bus write to the counter keeps the upper bits
		apb(1'b1, 8'h08, 32'hFFF, rd);
		rpc = {rpc[11:8], 8'hFF};
		apb(1'b0, 8'h08, 32'h0, rd);
		compare(rd, 32'(rpc));
		compare(32'(pc_o), 32'(rpc));
		// Status slot is not mapped here and reads zero
		apb(1'b0, 8'h0C, 32'h0, rd);
		compare(rd, 32'h0);
		// Misaligned access is flagged, its write dropped, reads zero
		apb(1'b1, 8'h41, 32'hFF, rd);
		compare(32'(slverr), 32'h1);
		apb(1'b0, 8'h42, 32'h0, rd);
		compare(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0, rd);
		compare(rd, 32'h34);
		compare(32'(slverr), 32'h0);
		// Reset in mid-run clears the counter while held
		do_op(pcs_pkg::PCS_OP_LONG_JUMP, 12'hABC, 8'h00);
		@(posedge clock_i);
		reset_n_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		#1;
		compare(32'(pc_o), 32'h0);
		compare(32'(stack_ptr_o), 32'h0);
		// Released again: the counter restarts from zero
		@(posedge clock_i);
		reset_n_i <= 1'b1;
		rpc = 12'h000;
		rsp = 3'h0;
		do_op(pcs_pkg::PCS_OP_STEP, 12'h000, 8'h00);
		do_op(pcs_pkg::PCS_OP_LONG_JUMP, 12'h7FF, 8'h00);
		results();
	end
endmodule
